// ---- include/urx_pkg.sv ----
// Constants and types for the serial receiver wakeup and flag block
package urx_pkg;
  localparam int ADDR_W = 3;
  // Register offsets
  localparam logic [2:0] OFF_CTRL1 = 3'h0;
  localparam logic [2:0] OFF_CTRL2 = 3'h1;
  localparam logic [2:0] OFF_CTRL3 = 3'h2;
  localparam logic [2:0] OFF_STAT1 = 3'h3;
  localparam logic [2:0] OFF_DATA  = 3'h4;
  localparam logic [2:0] OFF_BAUD  = 3'h5;
  // serial_control_reg_one fields
  localparam int C1_ENABLE = 6;
  localparam int C1_MODE9  = 4;
  localparam int C1_WAKE   = 3;
  localparam int C1_IDLE_COUNT_START_SELECT   = 2;
  localparam int C1_PEN    = 1;
  localparam int C1_PTY    = 0;
  // serial_control_reg_two fields
  localparam int C2_RFIE = 5;
  localparam int C2_IDLE_IRQ_ENABLE = 4;
  localparam int C2_RXEN = 2;
  localparam int C2_STBY = 1;
  // serial_control_reg_three fields
  localparam int C3_BIT8 = 7;
  localparam int C3_OVERRUN_IRQ_ENABLE = 3;
  localparam int C3_NOISE_IRQ_ENABLE = 2;
  localparam int C3_FRAMING_IRQ_ENABLE = 1;
  localparam int C3_PARITY_IRQ_ENABLE = 0;
  // serial_status_reg_one fields
  localparam int S1_RXFULL = 5;
  localparam int S1_IDLE   = 4;
  localparam int S1_OVR    = 3;
  localparam int S1_NOISE  = 2;
  localparam int S1_FRAME  = 1;
  localparam int S1_PAR    = 0;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DIV_RST  = 8'h1A;
  // Tick positions within one bit, sixteen ticks per bit
  localparam logic [4:0] RT_PER_BIT = 5'h10;
  localparam logic [4:0] RT_S3      = 5'h03;
  localparam logic [4:0] RT_S5      = 5'h05;
  localparam logic [4:0] RT_S7      = 5'h07;
  localparam logic [4:0] RT_S8      = 5'h08;
  localparam logic [4:0] RT_S9      = 5'h09;
  localparam logic [4:0] RT_S10     = 5'h0A;
  localparam logic [4:0] RT_EARLY   = 5'h06;
  localparam logic [4:0] RT_LATE    = 5'h0B;
  // Ticks from start edge to last stop sample
  localparam logic [7:0] STOP_TICK_8 = 8'h9A;
  localparam logic [7:0] STOP_TICK_9 = 8'hAA;
  // Frame lengths in bits
  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam logic [3:0] DATA_BITS_9 = 4'h9;
  localparam logic [3:0] IDLE_BITS_8 = 4'hA;
  localparam logic [3:0] IDLE_BITS_9 = 4'hB;
  typedef enum logic [1:0] {
    ST_SEARCH = 2'b00,
    ST_START  = 2'b01,
    ST_DATA   = 2'b10,
    ST_STOP   = 2'b11
  } urx_state_t;
endpackage

// ---- core/urx_rx_wakeup.sv ----
// Serial receiver with standby wakeup, status flags and request lines
`timescale 1ns/1ns
module urx_rx_wakeup #(
  parameter logic [7:0] DIV_RESET = urx_pkg::DIV_RST
) (
  input  wire logic                       clk_sys,
  input  wire logic                       nrst,
  input  wire logic [urx_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [7:0]                 regWdata,
  input  wire logic                       regWr,
  input  wire logic                       regRd,
  output logic      [7:0]                 regRdata,
  input  wire logic                       serialInputPin,
  input  wire logic                       waitMode,
  input  wire logic                       stopMode,
  input  wire logic                       breakState,
  input  wire logic                       breakClearPermit,
  output logic                            rxIrq,
  output logic                            errIrq,
  output logic                            waitWake
);
  import urx_pkg::*;

  if (DIV_RESET == 8'h00) begin : g_chk
    $error("DIV_RESET must be nonzero");
  end

  logic             pinMeta;
  logic             pinSync;
  logic [7:0]       ctrl1;
  logic [7:0]       ctrl2;
  logic [3:0]       ctrl3En;
  logic [7:0]       baudDiv;
  logic [7:0]       divCnt;
  logic             standby;
  logic [7:0]       dataReg;
  logic             bit8Reg;
  logic [5:0]       stat;
  logic [5:0]       armMask;
  logic [5:0]       clrVec;
  logic [5:0]       setVec;
  urx_state_t       state;
  logic [4:0]       rtCnt;
  logic [3:0]       bitIdx;
  logic             smpA;
  logic             smpB;
  logic [8:0]       frame;
  logic             chNoise;
  logic             lastOne;
  logic [2:0]       hist;
  logic [7:0]       charTicks;
  logic             resynced;
  logic             abortPend;
  logic [7:0]       onesCnt;
  logic             idleArm;

  // Register access is locked out in wait mode
  wire wrEn    = regWr && !waitMode;
  wire rdEn    = regRd && !waitMode;
  wire wrCtrl2 = wrEn && regAddr == OFF_CTRL2;
  wire mode9   = ctrl1[C1_MODE9];
  wire wake    = ctrl1[C1_WAKE];
  wire rxOn    = ctrl1[C1_ENABLE] && ctrl2[C2_RXEN];
  wire [3:0] nData    = mode9 ? DATA_BITS_9 : DATA_BITS_8;
  wire [3:0] idleBits = mode9 ? IDLE_BITS_9 : IDLE_BITS_8;
  wire [7:0] idleThr  = {idleBits, 4'h0};

  // Two flops on the pin; only pinSync is read by logic
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pinMeta <= 1'b1;
      pinSync <= 1'b1;
    end else begin
      pinMeta <= serialInputPin;
      pinSync <= pinMeta;
    end
  end

  // Control registers; standby kept apart since hardware clears it
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ctrl1   <= CTRL_RST;
      ctrl2   <= CTRL_RST;
      ctrl3En <= 4'h0;
      baudDiv <= DIV_RESET;
    end else if (wrEn) begin
      if (regAddr == OFF_CTRL1) ctrl1 <= regWdata;
      if (regAddr == OFF_CTRL2) ctrl2 <= regWdata;
      if (regAddr == OFF_CTRL3) ctrl3En <= regWdata[3:0];
      if (regAddr == OFF_BAUD) baudDiv <= regWdata;
    end
  end

  // Tick divider, held at zero in stop mode so nothing advances
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      divCnt <= 8'h00;
    end else if (stopMode || !rxOn) begin
      divCnt <= 8'h00;
    end else if (divCnt == baudDiv) begin
      divCnt <= 8'h00;
    end else begin
      divCnt <= divCnt + 8'h01;
    end
  end
  wire tick = rxOn && !stopMode && divCnt == baudDiv;

  // Sample votes: two stored samples plus the pin at the current tick
  wire [4:0] rtNow  = rtCnt + 5'h01;
  wire [7:0] ticksNow = charTicks + 8'h01;
  wire [2:0] votes  = {smpA, smpB, pinSync};
  wire maj = (smpA & smpB) | (smpA & pinSync) | (smpB & pinSync);
  wire dis = !(&votes) && (|votes);
  wire falling = hist[0] && !pinSync;
  wire resyncHit = state == ST_DATA && lastOne && falling &&
                   (rtNow >= RT_LATE || rtNow <= RT_EARLY);

  // Receive sequencer: search, start check, data bits, stop bit
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state     <= ST_SEARCH;
      rtCnt     <= 5'h00;
      bitIdx    <= 4'h0;
      smpA      <= 1'b1;
      smpB      <= 1'b1;
      frame     <= 9'h000;
      chNoise   <= 1'b0;
      lastOne   <= 1'b0;
      hist      <= 3'h7;
      charTicks <= 8'h00;
      resynced  <= 1'b0;
      abortPend <= 1'b0;
    end else begin
      // A character cut by stop mode is thrown away on release
      if (stopMode && state != ST_SEARCH) abortPend <= 1'b1;
      if (!rxOn || (abortPend && !stopMode)) begin
        state     <= ST_SEARCH;
        abortPend <= 1'b0;
      end else if (tick) begin
        hist      <= {hist[1:0], pinSync};
        charTicks <= ticksNow;
        unique case (state)
          ST_SEARCH: begin
            // Zero after three ones marks a possible start
            if (hist == 3'h7 && !pinSync) begin
              state     <= ST_START;
              rtCnt     <= 5'h01;
              charTicks <= 8'h01;
              frame     <= 9'h000;
              chNoise   <= 1'b0;
              lastOne   <= 1'b0;
              resynced  <= 1'b0;
            end
          end
          ST_START: begin
            rtCnt <= rtNow;
            if (rtNow == RT_S3) smpA <= pinSync;
            if (rtNow == RT_S5) smpB <= pinSync;
            if (rtNow == RT_S7) begin
              if (maj) state <= ST_SEARCH;
              else if (dis) chNoise <= 1'b1;
            end
            // Late ones in a verified start bit count as noise
            if ((rtNow == RT_S8 || rtNow == RT_S9 || rtNow == RT_S10) && pinSync)
              chNoise <= 1'b1;
            if (rtNow == RT_PER_BIT && state == ST_START) begin
              rtCnt  <= 5'h00;
              bitIdx <= 4'h1;
              state  <= ST_DATA;
            end
          end
          ST_DATA, ST_STOP: begin
            rtCnt <= rtNow;
            if (rtNow == RT_S8) smpA <= pinSync;
            if (rtNow == RT_S9) smpB <= pinSync;
            if (rtNow == RT_S10) begin
              if (dis) chNoise <= 1'b1;
              lastOne <= maj;
              if (state == ST_DATA) frame[bitIdx - 4'h1] <= maj;
              else state <= ST_SEARCH;
            end
            // Falling edge after a one restarts the bit phase
            if (resyncHit) begin
              rtCnt    <= 5'h01;
              lastOne  <= 1'b0;
              // Only a real phase shift counts; an edge on tick one moves nothing
              if (rtNow != 5'h01) resynced <= 1'b1;
              if (rtNow >= RT_LATE) begin
                if (bitIdx == nData) state <= ST_STOP;
                else bitIdx <= bitIdx + 4'h1;
              end
            end else if (rtNow == RT_PER_BIT && state == ST_DATA) begin
              rtCnt <= 5'h00;
              if (bitIdx == nData) state <= ST_STOP;
              else bitIdx <= bitIdx + 4'h1;
            end
          end
        endcase
      end
    end
  end

  // Character completion and what it carries
  wire charDone = tick && state == ST_STOP && rtNow == RT_S10 && !abortPend;
  wire msbNow   = mode9 ? frame[8] : frame[7];
  wire parBad   = ctrl1[C1_PEN] &&
                  ((mode9 ? ^frame : ^frame[7:0]) != ctrl1[C1_PTY]);
  wire frameBad = !maj;
  wire noiseNow = chNoise || dis;
  wire addrWake = standby && wake && msbNow;
  wire accept   = charDone && (!standby || addrWake);
  wire ovrNow   = accept && stat[S1_RXFULL] && !clrVec[S1_RXFULL];
  wire loadNow  = accept && !ovrNow;

  // Ones counter for idle detection; select picks where counting may run
  wire countOn = ctrl1[C1_IDLE_COUNT_START_SELECT] ? state == ST_SEARCH : state != ST_START;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      onesCnt <= 8'h00;
    end else if (!rxOn) begin
      onesCnt <= 8'h00;
    end else if (tick) begin
      if (!pinSync || !countOn) onesCnt <= 8'h00;
      else if (onesCnt != 8'hFF) onesCnt <= onesCnt + 8'h01;
    end
  end
  wire idleReached = onesCnt >= idleThr;
  // Already idle line wakes at once; accepted as a known quirk
  wire idleWake = standby && !wake && idleReached;
  wire idleEvt  = idleArm && idleReached && !standby;

  // Idle flag fires once per quiet period after some traffic
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      idleArm <= 1'b0;
    end else if (accept) begin
      idleArm <= 1'b1;
    end else if (idleEvt || idleWake) begin
      idleArm <= 1'b0;
    end
  end

  // Standby request: software sets it, wake events clear it
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      standby <= 1'b0;
    end else if (wrCtrl2) begin
      standby <= regWdata[C2_STBY];
    end else if ((charDone && addrWake) || idleWake) begin
      standby <= 1'b0;
    end
  end

  // Data register keeps the old byte on overrun
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      dataReg <= 8'h00;
      bit8Reg <= 1'b0;
    end else if (loadNow) begin
      dataReg <= frame[7:0];
      bit8Reg <= msbNow;
    end
  end

  // Two-step clear: status read then data read; break may freeze it
  wire clrOk    = !breakState || breakClearPermit;
  wire dataRead = rdEn && regAddr == OFF_DATA && clrOk;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      armMask <= 6'h00;
    end else if (rdEn && regAddr == OFF_STAT1 && clrOk) begin
      armMask <= stat;
    end else if (dataRead) begin
      armMask <= 6'h00;
    end
  end

  // Flag set terms and clear mask
  always_comb begin
    clrVec            = dataRead ? armMask : 6'h00;
    setVec            = 6'h00;
    setVec[S1_RXFULL] = loadNow;
    setVec[S1_IDLE]   = idleEvt;
    setVec[S1_OVR]    = ovrNow;
    setVec[S1_NOISE]  = loadNow && noiseNow;
    setVec[S1_FRAME]  = loadNow && frameBad;
    setVec[S1_PAR]    = loadNow && parBad;
  end

  // Status flags; a set in the clearing cycle wins
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      stat <= 6'h00;
    end else begin
      stat <= (stat & ~clrVec) | setVec;
    end
  end

  // Request lines, all held off during standby
  always_comb begin
    rxIrq  = !standby && ((stat[S1_RXFULL] && ctrl2[C2_RFIE]) ||
                          (stat[S1_IDLE] && ctrl2[C2_IDLE_IRQ_ENABLE]));
    errIrq = !standby && ((stat[S1_OVR] && ctrl3En[C3_OVERRUN_IRQ_ENABLE]) ||
                          (stat[S1_NOISE] && ctrl3En[C3_NOISE_IRQ_ENABLE]) ||
                          (stat[S1_FRAME] && ctrl3En[C3_FRAMING_IRQ_ENABLE]) ||
                          (stat[S1_PAR] && ctrl3En[C3_PARITY_IRQ_ENABLE]));
    waitWake = rxIrq || errIrq;
  end

  // Read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      regRdata <= 8'h00;
    end else if (rdEn) begin
      case (regAddr)
        OFF_CTRL1: regRdata <= ctrl1;
        OFF_CTRL2: regRdata <= {ctrl2[7:2], standby, ctrl2[0]};
        OFF_CTRL3: regRdata <= {bit8Reg, 3'h0, ctrl3En};
        OFF_STAT1: regRdata <= {2'h0, stat};
        OFF_DATA:  regRdata <= dataReg;
        OFF_BAUD:  regRdata <= baudDiv;
        default:   regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence sDoneClean;
    charDone && !resynced;
  endsequence
  sequence sAddrWake;
    charDone && addrWake && !stat[S1_RXFULL] && !wrCtrl2;
  endsequence
  sequence sStopped;
    stopMode ##1 stopMode;
  endsequence

  stop_tick_count_a: assert property (
    sDoneClean |-> ticksNow == (mode9 ? STOP_TICK_9 : STOP_TICK_8))
    else $error("stop sampling at wrong tick");
  stop_vote_a: assert property (
    charDone |-> (frameBad == ($countones(votes) < 2)) &&
                 ($countones(votes) != 2 || noiseNow))
    else $error("stop vote misjudged");
  standby_quiet_a: assert property (
    standby |-> !rxIrq && !errIrq)
    else $error("request during standby");
  addr_wake_a: assert property (
    sAddrWake |=> !standby && stat[S1_RXFULL])
    else $error("address mark did not wake");
  idle_wake_a: assert property (
    standby && !wake && idleReached && !wrCtrl2 |=>
      !standby && !$rose(stat[S1_IDLE]) && !$rose(stat[S1_RXFULL]))
    else $error("idle wake wrong");
  overrun_keep_a: assert property (
    ovrNow |=> stat[S1_OVR] && $stable(dataReg))
    else $error("overrun lost old data");
  wait_lock_a: assert property (
    waitMode && regWr |=> $stable(ctrl1) && $stable(ctrl3En) && $stable(baudDiv))
    else $error("write taken in wait mode");
  stop_hold_a: assert property (
    sStopped |-> $stable(state) && $stable(rtCnt) && $stable(stat))
    else $error("receiver moved in stop mode");
  break_guard_a: assert property (
    breakState && !breakClearPermit |=> ($past(stat) & ~stat) == 6'h00)
    else $error("flag cleared in protected break");
endmodule // urx_rx_wakeup

// ---- test/urx_tx_model.sv ----
// Remote serial transmitter model driving the receive line
`timescale 1ns/1ns
module urx_tx_model (
  input  wire logic clk_sys,
  output logic      serialLine
);
  // Line rests high between frames
  initial begin
    serialLine = 1'b1;
  end

  // One bit level held for a number of system clocks
  task automatic put_bit(input logic lvl, input int len);
    serialLine <= lvl;
    repeat (len) @(posedge clk_sys);
  endtask

  // Start bit, data lsb first, stop bit, then one idle bit time
  // Sixteen clocks per bit assumes the divisor is written as zero
  task automatic send(input logic [8:0] d, input int nb, input logic stopLvl);
    send_len(d, nb, stopLvl, 16);
  endtask

  // Same frame with every bit lasting len clocks, for a slow or fast sender
  task automatic send_len(input logic [8:0] d, input int nb, input logic stopLvl,
                          input int len);
    put_bit(1'b0, len);
    for (int i = 0; i < nb; i++) begin
      put_bit(d[i], len);
    end
    put_bit(stopLvl, len);
    put_bit(1'b1, len);
  endtask
endmodule // urx_tx_model

// ---- test/tb_uart_rx_wakeup_and_flags.sv ----
// Self-checking bench for the receiver wakeup and flag block
`timescale 1ns/1ns
module tb_uart_rx_wakeup_and_flags;
  import urx_pkg::*;
  logic       clk_sys;
  logic       nrst;
  logic [2:0] regAddr;
  logic [7:0] regWdata;
  logic       regWr;
  logic       regRd;
  logic [7:0] regRdata;
  logic       serialInputPin;
  logic       waitMode;
  logic       stopMode;
  logic       breakState;
  logic       breakClearPermit;
  logic       rxIrq;
  logic       errIrq;
  logic       waitWake;
  int         num_errors = 0;
  int         compares = 0;

  urx_rx_wakeup u_dut (
    .clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .serialInputPin(serialInputPin),
    .waitMode(waitMode), .stopMode(stopMode), .breakState(breakState),
    .breakClearPermit(breakClearPermit), .rxIrq(rxIrq), .errIrq(errIrq),
    .waitWake(waitWake));
  urx_tx_model u_tx (.clk_sys(clk_sys), .serialLine(serialInputPin));

  // Free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  function automatic logic [7:0] b(input int i);
    return 8'h01 << i;
  endfunction

  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic finish_test();
    if (num_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Bus cycles: strobes raised at one edge, dropped at the next
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask

  task automatic rdc(input string s, input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(s, e, d);
  endtask

  // Reset, then fastest tick and the given control values
  task automatic boot(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] c3);
    nrst <= 1'b0;
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    wr(OFF_BAUD, 8'h00);
    wr(OFF_CTRL1, c1);
    wr(OFF_CTRL2, c2);
    wr(OFF_CTRL3, c3);
  endtask

  // Clocks from start edge to the receive request, bounded
  task automatic timed(input logic [8:0] d, input int nb, input int last);
    int n;
    n = 0;
    fork
      u_tx.send(d, nb, 1'b1);
      while (rxIrq !== 1'b1 && n < 400) begin
        @(posedge clk_sys);
        #1 n++;
      end
    join
    compares++;
    if (n < last || n > last + 6) begin
      num_errors++;
      $display("MISMATCH flag delay expected %0d seen %0d", last, n);
    end
    if (n >= 400) finish_test();
  endtask

  task automatic s_reset();
    logic [7:0] e [7];
    e = '{CTRL_RST, CTRL_RST, 8'h00, 8'h00, 8'h00, DIV_RST, 8'h00};
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    chk("irq lines", 8'h00, {5'h00, rxIrq, errIrq, waitWake});
    for (int i = 0; i < 7; i++) begin
      rdc("reset value", 3'(i), e[i]);
    end
  endtask

  task automatic s_basic();
    boot(b(C1_ENABLE), b(C2_RXEN) | b(C2_RFIE) | b(C2_IDLE_IRQ_ENABLE), 8'h00);
    timed(9'h0A5, 8, 154);
    repeat (200) @(posedge clk_sys);
    rdc("status", OFF_STAT1, b(S1_RXFULL) | b(S1_IDLE));
    rdc("data", OFF_DATA, 8'hA5);
    rdc("status", OFF_STAT1, 8'h00);
    chk("rx irq", 8'h00, {7'h00, rxIrq});
  endtask

  task automatic s_nine();
    boot(b(C1_ENABLE) | b(C1_MODE9) | b(C1_IDLE_COUNT_START_SELECT), b(C2_RXEN) | b(C2_RFIE), 8'h00);
    timed(9'h13C, 9, 170);
    rdc("ninth bit", OFF_CTRL3, 8'h80);
    rdc("data", OFF_DATA, 8'h3C);
    // Counting after the stop bit puts idle about 26 ticks later than after the start
    repeat (139) @(posedge clk_sys);
    rdc("no idle yet", OFF_STAT1, b(S1_RXFULL));
    repeat (20) @(posedge clk_sys);
    rdc("idle", OFF_STAT1, b(S1_RXFULL) | b(S1_IDLE));
  endtask

  // Sender off by one clock per bit; without resync the last bits go wrong
  task automatic s_drift(input int len);
    boot(b(C1_ENABLE), b(C2_RXEN), 8'h00);
    u_tx.send_len(9'h055, 8, 1'b1, len);
    rdc("drift status", OFF_STAT1, b(S1_RXFULL));
    rdc("drift data", OFF_DATA, 8'h55);
  endtask

  // One low clock under the middle stop sample only
  task automatic s_noise();
    boot(b(C1_ENABLE), b(C2_RXEN), b(C3_NOISE_IRQ_ENABLE));
    u_tx.put_bit(1'b0, 16);
    u_tx.put_bit(1'b1, 136);
    u_tx.put_bit(1'b0, 1);
    u_tx.put_bit(1'b1, 23);
    chk("noise irq", 8'h01, {7'h00, errIrq});
    rdc("status", OFF_STAT1, b(S1_RXFULL) | b(S1_NOISE));
    rdc("data", OFF_DATA, 8'hFF);
  endtask

  task automatic s_overrun();
    boot(b(C1_ENABLE), b(C2_RXEN), b(C3_OVERRUN_IRQ_ENABLE));
    u_tx.send(9'h011, 8, 1'b1);
    u_tx.send(9'h022, 8, 1'b1);
    chk("rx irq off", 8'h00, {7'h00, rxIrq});
    chk("err irq", 8'h01, {7'h00, errIrq});
    rdc("status", OFF_STAT1, b(S1_RXFULL) | b(S1_OVR));
    rdc("old data", OFF_DATA, 8'h11);
    chk("err irq clr", 8'h00, {7'h00, errIrq});
  endtask

  // Framing fault and parity fault, each with its enable
  task automatic s_fault(input logic [7:0] c1, input logic [7:0] c3, input logic stopLvl,
                         input logic [7:0] flag);
    boot(c1, b(C2_RXEN), c3);
    u_tx.send(9'h001, 8, stopLvl);
    chk("err irq", 8'h01, {7'h00, errIrq});
    rdc("status", OFF_STAT1, b(S1_RXFULL) | flag);
  endtask

  task automatic s_standby();
    boot(b(C1_ENABLE) | b(C1_WAKE), b(C2_RXEN) | b(C2_STBY) | b(C2_RFIE), b(C3_FRAMING_IRQ_ENABLE));
    u_tx.send(9'h005, 8, 1'b0);
    chk("irq in standby", 8'h00, {6'h00, rxIrq, errIrq});
    rdc("status", OFF_STAT1, 8'h00);
    u_tx.send(9'h085, 8, 1'b1);
    rdc("standby off", OFF_CTRL2, b(C2_RXEN) | b(C2_RFIE));
    rdc("status", OFF_STAT1, b(S1_RXFULL));
    rdc("address", OFF_DATA, 8'h85);
    wr(OFF_CTRL2, b(C2_RXEN) | b(C2_STBY) | b(C2_RFIE));
    u_tx.send(9'h007, 8, 1'b1);
    rdc("ignored", OFF_STAT1, 8'h00);
  endtask

  task automatic s_idlewake();
    boot(b(C1_ENABLE), b(C2_RXEN) | b(C2_IDLE_IRQ_ENABLE), 8'h00);
    u_tx.send(9'h055, 8, 1'b1);
    rdc("status", OFF_STAT1, b(S1_RXFULL));
    rdc("data", OFF_DATA, 8'h55);
    wr(OFF_CTRL2, b(C2_RXEN) | b(C2_IDLE_IRQ_ENABLE) | b(C2_STBY));
    repeat (250) @(posedge clk_sys);
    rdc("woken", OFF_CTRL2, b(C2_RXEN) | b(C2_IDLE_IRQ_ENABLE));
    rdc("no flags", OFF_STAT1, 8'h00);
  endtask

  task automatic s_wait();
    boot(b(C1_ENABLE), b(C2_RXEN) | b(C2_RFIE), 8'h00);
    waitMode <= 1'b1;
    u_tx.send(9'h03C, 8, 1'b1);
    chk("wake", 8'h01, {7'h00, waitWake});
    rdc("locked read", OFF_STAT1, 8'h00);
    wr(OFF_CTRL2, 8'h00);
    waitMode <= 1'b0;
    rdc("ctrl kept", OFF_CTRL2, b(C2_RXEN) | b(C2_RFIE));
    rdc("status", OFF_STAT1, b(S1_RXFULL));
  endtask

  task automatic s_break();
    logic [7:0] d;
    boot(b(C1_ENABLE), b(C2_RXEN), 8'h00);
    u_tx.send(9'h044, 8, 1'b1);
    rd(OFF_STAT1, d);
    breakState <= 1'b1;
    rd(OFF_DATA, d);
    breakState <= 1'b0;
    rdc("held", OFF_STAT1, b(S1_RXFULL));
    rd(OFF_DATA, d);
    rdc("cleared", OFF_STAT1, 8'h00);
    u_tx.send(9'h045, 8, 1'b1);
    breakClearPermit <= 1'b1;
    breakState <= 1'b1;
    rd(OFF_STAT1, d);
    rd(OFF_DATA, d);
    breakState <= 1'b0;
    breakClearPermit <= 1'b0;
    rdc("stays clear", OFF_STAT1, 8'h00);
  endtask

  task automatic s_stop();
    boot(b(C1_ENABLE), b(C2_RXEN) | b(C2_RFIE), 8'h00);
    fork
      u_tx.send(9'h0FF, 8, 1'b1);
      begin
        repeat (60) @(posedge clk_sys);
        stopMode <= 1'b1;
        repeat (40) @(posedge clk_sys);
        stopMode <= 1'b0;
      end
    join
    rdc("discarded", OFF_STAT1, 8'h00);
    rdc("ctrl kept", OFF_CTRL2, b(C2_RXEN) | b(C2_RFIE));
    u_tx.send(9'h05A, 8, 1'b1);
    rdc("resumed", OFF_DATA, 8'h5A);
  endtask

  // Main sequence
  initial begin
    nrst = 1'b0;
    regAddr = 3'h0;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    waitMode = 1'b0;
    stopMode = 1'b0;
    breakState = 1'b0;
    breakClearPermit = 1'b0;
    s_reset();
    s_basic();
    s_nine();
    s_overrun();
    s_fault(b(C1_ENABLE), b(C3_FRAMING_IRQ_ENABLE), 1'b0, b(S1_FRAME));
    s_fault(b(C1_ENABLE) | b(C1_PEN), b(C3_PARITY_IRQ_ENABLE), 1'b1, b(S1_PAR));
    s_standby();
    s_idlewake();
    s_wait();
    s_break();
    s_stop();
    s_drift(17);
    s_drift(15);
    s_noise();
    finish_test();
  end
endmodule // tb_uart_rx_wakeup_and_flags
